// file: pviu_pkg.sv
// package: register map, bit fields, vectors and carrier types of the vectored irq unit
package pviu_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_HIGH = 8'h01;
  localparam logic [7:0] RST_CTRL_LOW = 8'h00;
  localparam logic [7:0] RST_CTRL_HIGH = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  // low register fields
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_EXT_EN = 1;
  localparam int BIT_TMR0_EN = 2;
  localparam int BIT_TMR1_EN = 3;
  localparam int BIT_EXT_FLAG = 4;
  localparam int BIT_TMR0_FLAG = 5;
  localparam int BIT_TMR1_FLAG = 6;
  localparam logic [7:0] LOW_WR_MASK = 8'h7F;
  // high register fields
  localparam int BIT_TMR2_EN = 0;
  localparam int BIT_RC_EN = 1;
  localparam int BIT_ADPCM_EN = 2;
  localparam int BIT_CH0_FLAG = 3;
  localparam int BIT_TMR2_FLAG = 4;
  localparam int BIT_RC_FLAG = 5;
  localparam int BIT_ADPCM_FLAG = 6;
  localparam int BIT_CH1_FLAG = 7;

  // ------------------------------------------------------------
  // sources and vectors, highest priority first
  // ------------------------------------------------------------
  localparam int NUM_SRC = 6;
  localparam int SRC_EXT = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_TMR1 = 2;
  localparam int SRC_TMR2 = 3;
  localparam int SRC_RC = 4;
  localparam int SRC_ADPCM = 5;
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] VEC_EXT = 8'h04;
  localparam logic [7:0] VEC_TMR0 = 8'h08;
  localparam logic [7:0] VEC_TMR1 = 8'h0C;
  localparam logic [7:0] VEC_TMR2 = 8'h10;
  localparam logic [7:0] VEC_RC = 8'h14;
  localparam logic [7:0] VEC_ADPCM = 8'h18;
  localparam int SYNC_W = 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h7;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] chan_empty;
    logic rc_tmr_b_ovf;
    logic rc_tmr_a_ovf;
    logic [2:0] tmr_ovf;
  } pviu_events_t;

  typedef struct packed {
    logic call;
    logic [7:0] vector;
    logic ret_pop;
  } pviu_core_cmd_t;

  typedef struct packed {
    logic [7:0] ctrl_low;
    logic [7:0] ctrl_high;
    logic [SYNC_W-1:0] pin_sync;
    logic [7:0] rdata;
    pviu_core_cmd_t cmd;
    logic wake;
  } pviu_state_t;

endpackage

// file: pviu_top.sv
// prioritized vectored interrupt unit with register port and core call/return interface
//
// The register addresses and strobed register access were left to the implementer.

// Function
// - falling pin edge sets external flag
// - external service needs global, enable, stack room
// - external entry clears its flag and global
// - pin counts only when enabled and input
// - accepted request pushes pc, jumps vector
// - return instruction pops saved program counter
// - stack full holds every request pending
// - flags other than external latch regardless of enables until cleared
// - software reenabling global allows nesting
// - requests taken on second clock phase
// - fixed priority with documented vector table
// - global enable low blocks all sources
// - timer enables at documented bit positions
// - timer flags at documented bit positions
// - timer overflow flags, entry clears flag, global
// - converter timers set flag, vector 14H
// - channel empty sets channel and summary flags
// - adpcm entry clears all three, global
// - any of the six source flags wakes from power down
// - only program counter saved on entry
module pviu_top (
  input wire logic i_core_clk,                          // system clock
  input wire logic i_rst_n,                             // async reset, active low
  input wire logic [pviu_pkg::ADDR_W-1:0] i_addr,       // register address
  input wire logic [7:0] i_wdata,                       // register write data
  input wire logic i_wr,                                // write strobe
  input wire logic i_rd,                                // read strobe
  output logic [7:0] o_rdata,                           // read data, cycle after read
  input wire logic i_port_a_bit_five,                   // external interrupt pin, async
  input wire logic i_port_a_dir_bit_five,               // port direction, 1 = input
  input wire pviu_pkg::pviu_events_t i_events,          // one-cycle peripheral events
  input wire logic i_second_clock_phase,                // sampling phase strobe
  input wire logic i_stack_full,                        // core stack has no room
  input wire logic i_reti,                              // core executes return
  output pviu_pkg::pviu_core_cmd_t o_cmd,               // call, vector, pop
  output logic o_wake                                   // wake request for power down
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pviu_pkg::pviu_state_t q, d;
  logic [pviu_pkg::NUM_SRC-1:0] req;
  logic [pviu_pkg::NUM_SRC-1:0] grant;
  logic ext_fall;
  logic ext_pin_on;
  logic take;
  logic [7:0] vec;
  logic wr_low;
  logic wr_high;
  logic [7:0] low_wr;
  logic [7:0] high_wr;
  logic [7:0] low_nxt;
  logic [7:0] high_nxt;
  logic entry_ext;
  logic entry_tmr0;
  logic entry_tmr1;
  logic entry_tmr2;
  logic entry_rc;
  logic entry_adpcm;
  logic set_ext;
  logic set_tmr0;
  logic set_tmr1;
  logic set_tmr2;
  logic set_rc;
  logic set_ch0;
  logic set_ch1;
  logic set_adpcm;
  logic [pviu_pkg::NUM_SRC-1:0] pend;
  logic any_pend;
  logic [7:0] rd_mux;

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  always_comb begin
    req[pviu_pkg::SRC_EXT] = q.ctrl_low[pviu_pkg::BIT_EXT_FLAG] & q.ctrl_low[pviu_pkg::BIT_EXT_EN];
    req[pviu_pkg::SRC_TMR0] = q.ctrl_low[pviu_pkg::BIT_TMR0_FLAG] & q.ctrl_low[pviu_pkg::BIT_TMR0_EN];
    req[pviu_pkg::SRC_TMR1] = q.ctrl_low[pviu_pkg::BIT_TMR1_FLAG] & q.ctrl_low[pviu_pkg::BIT_TMR1_EN];
    req[pviu_pkg::SRC_TMR2] = q.ctrl_high[pviu_pkg::BIT_TMR2_FLAG] & q.ctrl_high[pviu_pkg::BIT_TMR2_EN];
    req[pviu_pkg::SRC_RC] = q.ctrl_high[pviu_pkg::BIT_RC_FLAG] & q.ctrl_high[pviu_pkg::BIT_RC_EN];
    req[pviu_pkg::SRC_ADPCM] = q.ctrl_high[pviu_pkg::BIT_ADPCM_FLAG] & q.ctrl_high[pviu_pkg::BIT_ADPCM_EN];
    grant = '0;
    vec = pviu_pkg::VEC_RESET;
    if (req[pviu_pkg::SRC_EXT]) begin
      grant[pviu_pkg::SRC_EXT] = 1'b1;
      vec = pviu_pkg::VEC_EXT;
    end else if (req[pviu_pkg::SRC_TMR0]) begin
      grant[pviu_pkg::SRC_TMR0] = 1'b1;
      vec = pviu_pkg::VEC_TMR0;
    end else if (req[pviu_pkg::SRC_TMR1]) begin
      grant[pviu_pkg::SRC_TMR1] = 1'b1;
      vec = pviu_pkg::VEC_TMR1;
    end else if (req[pviu_pkg::SRC_TMR2]) begin
      grant[pviu_pkg::SRC_TMR2] = 1'b1;
      vec = pviu_pkg::VEC_TMR2;
    end else if (req[pviu_pkg::SRC_RC]) begin
      grant[pviu_pkg::SRC_RC] = 1'b1;
      vec = pviu_pkg::VEC_RC;
    end else if (req[pviu_pkg::SRC_ADPCM]) begin
      grant[pviu_pkg::SRC_ADPCM] = 1'b1;
      vec = pviu_pkg::VEC_ADPCM;
    end
    // taken only on the phase strobe
    take = i_second_clock_phase & q.ctrl_low[pviu_pkg::BIT_GLOBAL_EN] & ~i_stack_full & (|req);
    // pin path needs enable and input direction
    ext_pin_on = q.ctrl_low[pviu_pkg::BIT_EXT_EN] & i_port_a_dir_bit_five;
    ext_fall = q.pin_sync[2] & ~q.pin_sync[1];
  end

  // ------------------------------------------------------------
  // software write view
  // ------------------------------------------------------------
  always_comb begin
    wr_low = i_wr & (i_addr == pviu_pkg::OFS_CTRL_LOW);
    wr_high = i_wr & (i_addr == pviu_pkg::OFS_CTRL_HIGH);
    if (wr_low) begin
      low_wr = i_wdata & pviu_pkg::LOW_WR_MASK;
    end else begin
      low_wr = q.ctrl_low;
    end
    if (wr_high) begin
      high_wr = i_wdata;
    end else begin
      high_wr = q.ctrl_high;
    end
  end

  // ------------------------------------------------------------
  // service entry
  // ------------------------------------------------------------
  always_comb begin
    entry_ext = take & grant[pviu_pkg::SRC_EXT];
    entry_tmr0 = take & grant[pviu_pkg::SRC_TMR0];
    entry_tmr1 = take & grant[pviu_pkg::SRC_TMR1];
    entry_tmr2 = take & grant[pviu_pkg::SRC_TMR2];
    entry_rc = take & grant[pviu_pkg::SRC_RC];
    entry_adpcm = take & grant[pviu_pkg::SRC_ADPCM];
  end

  // ------------------------------------------------------------
  // hardware events
  // ------------------------------------------------------------
  always_comb begin
    set_ext = ext_fall & ext_pin_on;
    set_tmr0 = i_events.tmr_ovf[0];
    set_tmr1 = i_events.tmr_ovf[1];
    set_tmr2 = i_events.tmr_ovf[2];
    set_rc = i_events.rc_tmr_a_ovf | i_events.rc_tmr_b_ovf;
    set_ch0 = i_events.chan_empty[0];
    set_ch1 = i_events.chan_empty[1];
    set_adpcm = set_ch0 | set_ch1;
  end

  // ------------------------------------------------------------
  // low register next value
  // ------------------------------------------------------------
  always_comb begin
    low_nxt = low_wr;
    // global cleared, software may set it again
    if (take) begin
      low_nxt[pviu_pkg::BIT_GLOBAL_EN] = 1'b0;
    end
    if (entry_ext) begin
      low_nxt[pviu_pkg::BIT_EXT_FLAG] = 1'b0;
    end
    if (set_ext) begin
      low_nxt[pviu_pkg::BIT_EXT_FLAG] = 1'b1;
    end
    if (entry_tmr0) begin
      low_nxt[pviu_pkg::BIT_TMR0_FLAG] = 1'b0;
    end
    if (set_tmr0) begin
      low_nxt[pviu_pkg::BIT_TMR0_FLAG] = 1'b1;
    end
    if (entry_tmr1) begin
      low_nxt[pviu_pkg::BIT_TMR1_FLAG] = 1'b0;
    end
    if (set_tmr1) begin
      low_nxt[pviu_pkg::BIT_TMR1_FLAG] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // high register next value
  // ------------------------------------------------------------
  always_comb begin
    high_nxt = high_wr;
    if (entry_tmr2) begin
      high_nxt[pviu_pkg::BIT_TMR2_FLAG] = 1'b0;
    end
    if (set_tmr2) begin
      high_nxt[pviu_pkg::BIT_TMR2_FLAG] = 1'b1;
    end
    if (entry_rc) begin
      high_nxt[pviu_pkg::BIT_RC_FLAG] = 1'b0;
    end
    if (set_rc) begin
      high_nxt[pviu_pkg::BIT_RC_FLAG] = 1'b1;
    end
    // adpcm entry clears summary and both channels
    if (entry_adpcm) begin
      high_nxt[pviu_pkg::BIT_ADPCM_FLAG] = 1'b0;
      high_nxt[pviu_pkg::BIT_CH0_FLAG] = 1'b0;
      high_nxt[pviu_pkg::BIT_CH1_FLAG] = 1'b0;
    end
    if (set_ch0) begin
      high_nxt[pviu_pkg::BIT_CH0_FLAG] = 1'b1;
    end
    if (set_ch1) begin
      high_nxt[pviu_pkg::BIT_CH1_FLAG] = 1'b1;
    end
    if (set_adpcm) begin
      high_nxt[pviu_pkg::BIT_ADPCM_FLAG] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // pending flags, enables ignored
  // ------------------------------------------------------------
  always_comb begin
    pend[pviu_pkg::SRC_EXT] = low_nxt[pviu_pkg::BIT_EXT_FLAG];
    pend[pviu_pkg::SRC_TMR0] = low_nxt[pviu_pkg::BIT_TMR0_FLAG];
    pend[pviu_pkg::SRC_TMR1] = low_nxt[pviu_pkg::BIT_TMR1_FLAG];
    pend[pviu_pkg::SRC_TMR2] = high_nxt[pviu_pkg::BIT_TMR2_FLAG];
    pend[pviu_pkg::SRC_RC] = high_nxt[pviu_pkg::BIT_RC_FLAG];
    pend[pviu_pkg::SRC_ADPCM] = high_nxt[pviu_pkg::BIT_ADPCM_FLAG];
    any_pend = |pend;
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = pviu_pkg::RDATA_IDLE;
    if (i_rd) begin
      case (i_addr)
        pviu_pkg::OFS_CTRL_LOW: rd_mux = q.ctrl_low;
        pviu_pkg::OFS_CTRL_HIGH: rd_mux = q.ctrl_high;
        default: rd_mux = pviu_pkg::RDATA_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.pin_sync = {q.pin_sync[1:0], i_port_a_bit_five};
    // read port
    d.rdata = rd_mux;
    // only the pc is pushed by the core
    d.cmd.call = take;
    d.cmd.vector = take ? vec : pviu_pkg::VEC_RESET;
    d.cmd.ret_pop = i_reti;
    d.ctrl_low = low_nxt;
    d.ctrl_high = high_nxt;
    // any pending flag wakes the part
    d.wake = any_pend;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q.ctrl_low <= pviu_pkg::RST_CTRL_LOW;
      q.ctrl_high <= pviu_pkg::RST_CTRL_HIGH;
      q.pin_sync <= pviu_pkg::SYNC_RST;
      q.rdata <= pviu_pkg::RDATA_IDLE;
      q.cmd.call <= 1'b0;
      q.cmd.vector <= pviu_pkg::VEC_RESET;
      q.cmd.ret_pop <= 1'b0;
      q.wake <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_cmd = q.cmd;
  assign o_wake = q.wake;

endmodule

// file: pviu_chk_asserts.sv
// port checker of the vectored irq unit
module pviu_chk (
  input wire logic i_core_clk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic [pviu_pkg::ADDR_W-1:0] i_addr, // address
  input wire logic i_rd, // read strobe
  input wire logic [7:0] o_rdata, // read data
  input wire pviu_pkg::pviu_events_t i_events, // events
  input wire logic i_second_clock_phase, // phase strobe
  input wire logic i_stack_full, // stack full
  input wire logic i_reti, // return
  input wire pviu_pkg::pviu_core_cmd_t o_cmd, // core command
  input wire logic o_wake // wake
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_call_cause: assert property (o_cmd.call |-> $past(i_second_clock_phase) && !$past(i_stack_full))
    else $error("call without phase or with full stack");
  a_call_pulse: assert property (o_cmd.call |=> !o_cmd.call)
    else $error("second call without reenable");
  a_vec_table: assert property (o_cmd.call |-> o_cmd.vector inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18})
    else $error("call vector outside table");
  a_vec_idle: assert property (!o_cmd.call |-> o_cmd.vector == 8'h00)
    else $error("vector without call");
  a_ret_pop: assert property (i_reti |=> o_cmd.ret_pop)
    else $error("return not popped");
  a_pop_cause: assert property (o_cmd.ret_pop |-> $past(i_reti))
    else $error("pop without return");
  a_event_wake: assert property (|i_events |-> ##[1:2] o_wake)
    else $error("event gave no wake");
  a_rdata_idle: assert property (!$past(i_rd) || $past(i_addr) > 8'h01 |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_low_bit7: assert property ($past(i_rd) && $past(i_addr) == pviu_pkg::OFS_CTRL_LOW |-> !o_rdata[7])
    else $error("low register bit 7 set");
  c_call: cover property (o_cmd.call);
  c_pop: cover property (o_cmd.ret_pop);
  c_full: cover property (i_stack_full && i_second_clock_phase);
endmodule

bind pviu_top pviu_chk i_chk (.*);

// file: pviu_core_mdl.sv
// core stack model: pushes on call, pops on return
module pviu_core_mdl #(
  parameter int DEPTH = 1
) (
  input wire logic i_core_clk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire pviu_pkg::pviu_core_cmd_t i_cmd, // unit command
  output logic o_stack_full // no room left
);
  logic [3:0] depth_q;
  assign o_stack_full = (depth_q == 4'(DEPTH));
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      depth_q <= 4'h0;
    end else if (i_cmd.call) begin
      depth_q <= depth_q + 4'h1;
    end else if (i_cmd.ret_pop) begin
      depth_q <= depth_q - 4'h1;
    end
  end
endmodule

// file: tb_top.sv
// self-checking bench of the vectored irq unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_rst_n, i_wr, i_rd, i_reti, i_stack_full, o_wake;
  logic i_port_a_bit_five, i_port_a_dir_bit_five, i_second_clock_phase;
  logic [pviu_pkg::ADDR_W-1:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  pviu_pkg::pviu_events_t i_events;
  pviu_pkg::pviu_core_cmd_t o_cmd;
  int fail_count, compares;
  pviu_top i_dut (.*);
  pviu_core_mdl #(.DEPTH(1)) i_core (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cmd(o_cmd),
    .o_stack_full(i_stack_full));
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= w;
    i_rd <= !w;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    if (!w) #1 chk(o_rdata, d);
  endtask
  task automatic svc(input logic [7:0] v);
    @(posedge i_core_clk);
    i_second_clock_phase <= 1'b1;
    @(posedge i_core_clk);
    i_second_clock_phase <= 1'b0;
    #1 chk({7'h00, o_cmd.call}, {7'h00, v != 8'h00}); // phase call
    chk(o_cmd.vector, v); // vector
  endtask
  task automatic ret();
    @(posedge i_core_clk);
    i_reti <= 1'b1;
    @(posedge i_core_clk);
    i_reti <= 1'b0;
    #1 chk({7'h00, o_cmd.ret_pop}, 8'h01); // pop
  endtask
  task automatic ev(input logic [6:0] e);
    @(posedge i_core_clk);
    i_events <= e;
    @(posedge i_core_clk);
    i_events <= '0;
  endtask
  task automatic fall();
    i_port_a_bit_five <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    i_port_a_bit_five <= 1'b0;
    repeat (5) @(posedge i_core_clk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    chk({7'h00, o_wake}, 8'h00); // idle wake
    bus(0, pviu_pkg::OFS_CTRL_LOW, pviu_pkg::RST_CTRL_LOW);
    bus(0, pviu_pkg::OFS_CTRL_HIGH, pviu_pkg::RST_CTRL_HIGH);
    bus(1, pviu_pkg::OFS_CTRL_LOW, 8'hFE);
    bus(0, pviu_pkg::OFS_CTRL_LOW, 8'h7E); // bit map
    bus(1, 8'h02, 8'hFF);
    bus(0, 8'h02, 8'h00);
  endtask
  task automatic t_prio();
    logic [7:0] lm [6] = '{8'h10, 8'h20, 8'h40, 8'h00, 8'h00, 8'h00};
    logic [7:0] hm [6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h20, 8'hC8};
    logic [7:0] lo = 8'h7F;
    logic [7:0] hi = 8'hFF;
    bus(1, pviu_pkg::OFS_CTRL_HIGH, hi);
    for (int i = 0; i < 6; i++) begin
      bus(1, pviu_pkg::OFS_CTRL_LOW, lo | 8'h01);
      svc(8'h04 + 8'(4 * i)); // order
      lo = lo & ~lm[i] & 8'hFE;
      hi = hi & ~hm[i];
      bus(0, pviu_pkg::OFS_CTRL_LOW, lo); // entry clear
      bus(0, pviu_pkg::OFS_CTRL_HIGH, hi); // entry clear
      ret();
    end
  endtask
  task automatic t_events();
    bus(1, pviu_pkg::OFS_CTRL_LOW, 8'h0E);
    ev(7'h55);
    svc(8'h00); // global off
    bus(0, pviu_pkg::OFS_CTRL_LOW, 8'h2E); // latched
    bus(0, pviu_pkg::OFS_CTRL_HIGH, 8'hF7); // flags
    chk({7'h00, o_wake}, 8'h01); // wake
    bus(1, pviu_pkg::OFS_CTRL_LOW, 8'h0E);
    bus(1, pviu_pkg::OFS_CTRL_HIGH, 8'h07);
    ev(7'h2A);
    bus(0, pviu_pkg::OFS_CTRL_LOW, 8'h4E); // timer one
    bus(0, pviu_pkg::OFS_CTRL_HIGH, 8'h6F); // flags
  endtask
  task automatic t_ext();
    bus(1, pviu_pkg::OFS_CTRL_LOW, 8'h02);
    i_port_a_dir_bit_five <= 1'b1;
    fall();
    bus(0, pviu_pkg::OFS_CTRL_LOW, 8'h12); // fall sets
    bus(1, pviu_pkg::OFS_CTRL_LOW, 8'h02);
    i_port_a_dir_bit_five <= 1'b0;
    fall();
    bus(0, pviu_pkg::OFS_CTRL_LOW, 8'h02); // output ignored
    bus(1, pviu_pkg::OFS_CTRL_LOW, 8'h03);
    i_port_a_dir_bit_five <= 1'b1;
    fall();
    svc(8'h04); // pin call
    ret();
  endtask
  task automatic t_stack();
    bus(1, pviu_pkg::OFS_CTRL_LOW, 8'h25);
    svc(8'h08); // timer call
    bus(1, pviu_pkg::OFS_CTRL_LOW, 8'h49);
    svc(8'h00); // full blocks
    bus(0, pviu_pkg::OFS_CTRL_LOW, 8'h49); // held
    ret();
    svc(8'h0C); // held call after pop
    ret();
  endtask
  initial begin
    fail_count = 0;
    compares = 0;
    i_rst_n = 1'b0;
    {i_wr, i_rd, i_reti, i_second_clock_phase, i_port_a_dir_bit_five} = '0;
    i_port_a_bit_five = 1'b1;
    i_addr = '0;
    i_wdata = '0;
    i_events = '0;
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_prio();
    t_events();
    t_ext();
    t_stack();
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge i_core_clk);
    fail_count++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
endmodule
